// *** design/ras_top.sv ***
// Return-address stack with pointer/overflow register on APB.
// Assumes call, ret and irq_pending come from core logic on clock.
//
// Summary of operation
// - Sixteen-level stack holds program counters only; entries not software visible.
// - Low four bits of the pointer register select the active level.
// - Call or interrupt acknowledge pushes the PC and advances the pointer.
// - Return decrements the pointer and reloads PC from the stack.
// - Reset clears pointer to zero and clears the overflow flag.
// - Pending interrupt with full stack is held; no acknowledge, no push.
// - After a return frees a level the held interrupt is acknowledged.
// - Call with full stack still pushes, overwriting the oldest entry.
// - Overflow flag bit 7 sets on full call or empty return.
// - Only software or reset clears the flag; pointer bits are read-only.
// - A set flag stays high through any number of returns.
// - Pointer counts calls modulo sixteen; seventeenth call sets the flag.
// - Empty return decrements the pointer, wrapping zero to fifteen, and sets the flag.
// - Bits six to four of the pointer register read zero.
`timescale 1ns/100ps
`default_nettype none
module ras_top
  import ras_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire ras_core_req_t core_req,
  output ras_core_rsp_t core_rsp
);
  logic [RAS_PTR_W-1:0] ptr_r, ptr_nxt;
  logic [RAS_CNT_W-1:0] cnt_r, cnt_nxt;
  logic osf_r, osf_nxt;
  ras_core_rsp_t rsp_r, rsp_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [RAS_PTR_W-1:0] rd_addr;
  logic [RAS_PC_W-1:0] rd_pc;
  logic stack_full, stack_empty, do_ack, do_push, do_pop;
  logic apb_acc, apb_wr_stk, apb_hit, osf_clr;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign core_rsp = rsp_r;

  // Occupancy decode and push/pop decisions
  always_comb
  begin
    stack_full = (cnt_r == RAS_CNT_FULL);
    stack_empty = (cnt_r == RAS_CNT_RST);
    // Held off while full; granted once a level is free
    do_ack = core_req.irq_pending && !stack_full
      && !core_req.call && !core_req.ret;
    do_push = core_req.call || do_ack;
    do_pop = core_req.ret && !core_req.call;
    rd_addr = ptr_r - 4'h1;
  end

  ras_storage #(
    .DEPTH(RAS_DEPTH),
    .AW(RAS_PTR_W),
    .DW(RAS_PC_W)
  ) u_storage (
    .clock(clock),
    .wr_en(do_push),
    .wr_addr(ptr_r),
    .wr_data(core_req.pc),
    .rd_addr(rd_addr),
    .rd_data(rd_pc)
  );

  // APB decode
  always_comb
  begin
    apb_acc = psel && penable && !pready_r;
    apb_hit = (paddr == RAS_OFS_STACK_POINTER_REG);
    apb_wr_stk = apb_acc && pwrite && apb_hit && pstrb[0];
    osf_clr = apb_wr_stk && !pwdata[RAS_OSF_BIT];
  end

  // Pointer, occupancy and overflow next state
  always_comb
  begin
    ptr_nxt = ptr_r;
    cnt_nxt = cnt_r;
    osf_nxt = osf_r;
    if (osf_clr)
    begin
      osf_nxt = 1'b0;
    end
    if (apb_wr_stk && pwdata[RAS_OSF_BIT])
    begin
      osf_nxt = 1'b1;
    end
    if (do_push)
    begin
      ptr_nxt = ptr_r + 4'h1;
      if (stack_full)
      begin
        osf_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r + 5'h01;
      end
    end
    else if (do_pop)
    begin
      ptr_nxt = ptr_r - 4'h1;
      if (stack_empty)
      begin
        osf_nxt = 1'b1;
      end
      else
      begin
        cnt_nxt = cnt_r - 5'h01;
      end
    end
  end

  // Answer to the core
  always_comb
  begin
    rsp_nxt.irq_ack = do_ack;
    rsp_nxt.pc_load = do_pop;
    rsp_nxt.pc = do_pop ? rd_pc : rsp_r.pc;
  end

  // APB answer, one wait state
  always_comb
  begin
    pready_nxt = apb_acc;
    pslverr_nxt = apb_acc && !apb_hit
      && (paddr != RAS_OFS_LEVEL);
    prdata_nxt = 32'h0000_0000;
    if (apb_acc && !pwrite && apb_hit)
    begin
      prdata_nxt = {24'h000000, osf_r, 3'h0, ptr_r};
    end
    else if (apb_acc && !pwrite && paddr == RAS_OFS_LEVEL)
    begin
      prdata_nxt = {27'h0000000, cnt_r};
    end
  end

  // Register all state
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      ptr_r <= RAS_PTR_RST;
      cnt_r <= RAS_CNT_RST;
      osf_r <= RAS_STACK_POINTER_REG_RST[RAS_OSF_BIT];
      rsp_r <= '0;
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      ptr_r <= ptr_nxt;
      cnt_r <= cnt_nxt;
      osf_r <= osf_nxt;
      rsp_r <= rsp_nxt;
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Checks
  property p_reset_clear;
    @(posedge clock) srst |=> (ptr_r == 4'h0 && !osf_r && cnt_r == 5'h00);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("reset did not clear pointer state");

  property p_push_adv;
    @(posedge clock) disable iff (srst)
      do_push |=> ptr_r == $past(ptr_r) + 4'h1;
  endproperty
  a_push_adv: assert property (p_push_adv)
    else $error("push did not advance pointer");

  property p_pop_dec;
    @(posedge clock) disable iff (srst)
      do_pop |=> (ptr_r == $past(ptr_r) - 4'h1) && core_rsp.pc_load;
  endproperty
  a_pop_dec: assert property (p_pop_dec)
    else $error("pop did not decrement pointer");

  property p_no_ack_full;
    @(posedge clock) disable iff (srst)
      stack_full && !core_req.ret |=> !core_rsp.irq_ack;
  endproperty
  a_no_ack_full: assert property (p_no_ack_full)
    else $error("ack given with stack full");

  sequence s_held;
    core_req.irq_pending && stack_full;
  endsequence
  sequence s_freed;
    core_req.ret ##1 (core_req.irq_pending && !core_req.call
      && !core_req.ret);
  endsequence
  property p_ack_after_ret;
    @(posedge clock) disable iff (srst)
      s_held ##0 s_freed |=> core_rsp.irq_ack;
  endproperty
  a_ack_after_ret: assert property (p_ack_after_ret)
    else $error("held interrupt not acknowledged");

  property p_full_call_osf;
    @(posedge clock) disable iff (srst)
      core_req.call && stack_full |=> osf_r && ptr_r == $past(ptr_r) + 4'h1;
  endproperty
  a_full_call_osf: assert property (p_full_call_osf)
    else $error("full call did not set overflow");

  property p_osf_sticky;
    @(posedge clock) disable iff (srst)
      osf_r && !apb_wr_stk |=> osf_r;
  endproperty
  a_osf_sticky: assert property (p_osf_sticky)
    else $error("overflow flag cleared by hardware");

  property p_empty_wrap;
    @(posedge clock) disable iff (srst)
      do_pop && stack_empty && ptr_r == 4'h0 |=> ptr_r == 4'hF && osf_r;
  endproperty
  a_empty_wrap: assert property (p_empty_wrap)
    else $error("empty return did not wrap");

  property p_cnt_range;
    @(posedge clock) disable iff (srst) cnt_r <= RAS_CNT_FULL;
  endproperty
  a_cnt_range: assert property (p_cnt_range)
    else $error("occupancy out of range");

  property p_rsvd_zero;
    @(posedge clock) disable iff (srst) pready |-> prdata[6:4] == 3'h0;
  endproperty
  a_rsvd_zero: assert property (p_rsvd_zero)
    else $error("reserved bits not zero");

  property p_ack_push;
    @(posedge clock) disable iff (srst)
      do_ack |=> core_rsp.irq_ack && ptr_r == $past(ptr_r) + 4'h1;
  endproperty
  a_ack_push: assert property (p_ack_push)
    else $error("acknowledge did not push");

  property p_cnt_inc;
    @(posedge clock) disable iff (srst)
      do_push && !stack_full |=> cnt_r == $past(cnt_r) + 5'h01;
  endproperty
  a_cnt_inc: assert property (p_cnt_inc)
    else $error("occupancy did not count a push");

  property p_call_flag_keep;
    @(posedge clock) disable iff (srst)
      do_push && !stack_full && !apb_wr_stk |=> osf_r == $past(osf_r);
  endproperty
  a_call_flag_keep: assert property (p_call_flag_keep)
    else $error("overflow flag changed on a call with room");

  property p_empty_ret_osf;
    @(posedge clock) disable iff (srst)
      do_pop && stack_empty |=> osf_r;
  endproperty
  a_empty_ret_osf: assert property (p_empty_ret_osf)
    else $error("empty return did not set overflow");

  property p_pop_pc;
    @(posedge clock) disable iff (srst)
      do_pop |=> core_rsp.pc == $past(rd_pc);
  endproperty
  a_pop_pc: assert property (p_pop_pc)
    else $error("popped value not returned");

  property p_ptr_ro;
    @(posedge clock) disable iff (srst)
      apb_wr_stk && !do_push && !do_pop |=> ptr_r == $past(ptr_r);
  endproperty
  a_ptr_ro: assert property (p_ptr_ro)
    else $error("register write moved the pointer");

  property p_osf_clr;
    @(posedge clock) disable iff (srst)
      osf_clr && !(do_push && stack_full) && !(do_pop && stack_empty)
      |=> !osf_r;
  endproperty
  a_osf_clr: assert property (p_osf_clr)
    else $error("software clear of overflow flag lost");
endmodule : ras_top
`default_nettype wire

// *** design/ras_pkg.sv ***
// Package for the return-address stack: register map, fields, resets.
// Assumes a 32-bit APB slave port and a 15-bit program counter.
package ras_pkg;
  localparam int RAS_DEPTH = 16;
  localparam int RAS_PTR_W = 4;
  localparam int RAS_PC_W = 15;
  localparam int RAS_CNT_W = 5;
  localparam logic [11:0] RAS_OFS_STACK_POINTER_REG = 12'h000;
  localparam logic [11:0] RAS_OFS_LEVEL = 12'h004;
  localparam int RAS_OSF_BIT = 7;
  localparam logic [7:0] RAS_STACK_POINTER_REG_RST = 8'h00;
  localparam logic [RAS_PTR_W-1:0] RAS_PTR_RST = 4'h0;
  localparam logic [RAS_CNT_W-1:0] RAS_CNT_RST = 5'h00;
  localparam logic [RAS_CNT_W-1:0] RAS_CNT_FULL = 5'h10;

  // Core-side request group
  typedef struct packed {
    logic call;
    logic ret;
    logic irq_pending;
    logic [RAS_PC_W-1:0] pc;
  } ras_core_req_t;

  // Answer back to the core
  typedef struct packed {
    logic irq_ack;
    logic pc_load;
    logic [RAS_PC_W-1:0] pc;
  } ras_core_rsp_t;
endpackage : ras_pkg

// *** design/ras_storage.sv ***
// Storage array for saved program counters, one write and one read port.
// Assumes a single clock; not reset since entries are never visible.
`timescale 1ns/100ps
`default_nettype none
module ras_storage
  import ras_pkg::*;
#(
  parameter int DEPTH = RAS_DEPTH,
  parameter int AW = RAS_PTR_W,
  parameter int DW = RAS_PC_W
)
(
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [DEPTH];

  // Write on push, oldest entry overwritten when wrapped
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Combinational read of the level below the pointer
  always_comb
  begin
    rd_data = mem[rd_addr];
  end
endmodule : ras_storage
`default_nettype wire

// *** tb/ras_core_model.sv ***
// Core sequencer and interrupt logic model facing the stack.
// Assumes bench commands change right after rising clock edges.
`timescale 1ns/100ps
`default_nettype none
module ras_core_model
  import ras_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic do_call,
  input wire logic do_ret,
  input wire logic do_irq,
  input wire logic [RAS_PC_W-1:0] pc_cmd,
  input wire ras_core_rsp_t core_rsp,
  output ras_core_req_t core_req
);
  logic call_r, ret_r, irq_r;
  logic [RAS_PC_W-1:0] pc_r;
  // Interrupt flag stays latched until the stack acknowledges it
  always_ff @(posedge clock)
  begin
    call_r <= do_call & ~srst;
    ret_r <= do_ret & ~srst;
    pc_r <= pc_cmd;
    if (srst || core_rsp.irq_ack)
    begin
      irq_r <= 1'b0;
    end
    else if (do_irq)
    begin
      irq_r <= 1'b1;
    end
  end
  // Pending drops in the acknowledge cycle, so no second push
  assign core_req = '{call_r, ret_r, irq_r & ~core_rsp.irq_ack, pc_r};
endmodule : ras_core_model
`default_nettype wire

// *** tb/test_ras_top.sv ***
// Self-checking bench for the return-address stack.
// Assumes the APB slave answers with pready and the core model alongside.
`timescale 1ns/100ps
`default_nettype none
module test_ras_top
  import ras_pkg::*;
;
  logic clock = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic do_call = 0, do_ret = 0, do_irq = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [RAS_PC_W-1:0] pc_cmd = '0;
  ras_core_req_t core_req;
  ras_core_rsp_t core_rsp;
  int n_mismatch = 0, tests_run = 0, k;
  // Clock of 4 ns
  always #2 clock = ~clock;
  ras_top ras_top_i (.clock(clock), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .core_req(core_req), .core_rsp(core_rsp));
  ras_core_model ras_core_model_i (.clock(clock), .srst(srst),
    .do_call(do_call), .do_ret(do_ret), .do_irq(do_irq),
    .pc_cmd(pc_cmd), .core_rsp(core_rsp), .core_req(core_req));
  // Verdict and end of run
  task test_done;
    if (n_mismatch == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done
  // Compare and report
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bound on a wait that ran out
  task lim(input int i);
    if (i >= 20)
    begin
      n_mismatch++;
      test_done;
    end
  endtask : lim
  // One APB transfer, setup then access until pready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    lim(i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One core command lasting one cycle
  task op(input logic c, input logic r, input logic q, input int p);
    @(posedge clock);
    do_call <= c;
    do_ret <= r;
    do_irq <= q;
    pc_cmd <= RAS_PC_W'(p);
    @(posedge clock);
    do_call <= 1'b0;
    do_ret <= 1'b0;
    do_irq <= 1'b0;
  endtask : op
  // Wait for acknowledge (a=1) or program counter reload (a=0)
  task wrsp(input logic a);
    int i;
    i = 0;
    do
    begin
      @(posedge clock);
      i++;
    end
    while ((a ? core_rsp.irq_ack : core_rsp.pc_load) !== 1'b1 && i < 20);
    lim(i);
  endtask : wrsp
  // Reset values and an unmapped address
  task sc_reset;
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
  endtask : sc_reset
  // Sixteen calls wrap the pointer, the seventeenth overflows
  task sc_call_wrap;
    for (k = 1; k <= 16; k++)
    begin
      op(1'b1, 1'b0, 1'b0, k);
    end
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h0);
    op(1'b1, 1'b0, 1'b0, 17);
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h81);
  endtask : sc_call_wrap
  // Return after overflow, sticky flag, software clear
  task sc_ret_flag;
    op(1'b0, 1'b1, 1'b0, 0);
    wrsp(1'b0);
    chk({17'h0, core_rsp.pc}, 32'h11);
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h80);
    apb(1'b1, RAS_OFS_STACK_POINTER_REG, 32'h0F);
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, RAS_OFS_LEVEL, 32'h0);
    chk(rd, 32'hF);
  endtask : sc_ret_flag
  // Interrupt held while full, served once a return frees a level
  task sc_irq_hold;
    op(1'b1, 1'b0, 1'b0, 16'h55);
    op(1'b0, 1'b0, 1'b1, 0);
    repeat (8)
    begin
      @(posedge clock);
      chk({31'h0, core_rsp.irq_ack}, 32'h0);
    end
    op(1'b0, 1'b1, 1'b0, 0);
    wrsp(1'b0);
    chk({17'h0, core_rsp.pc}, 32'h55);
    wrsp(1'b1);
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h1);
  endtask : sc_irq_hold
  // Reset in mid-run, then returns from an empty stack
  task sc_underflow;
    srst <= 1'b1;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h0);
    op(1'b0, 1'b1, 1'b0, 0);
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h8F);
    for (k = 0; k < 15; k++)
    begin
      op(1'b0, 1'b1, 1'b0, 0);
    end
    apb(1'b0, RAS_OFS_STACK_POINTER_REG, 32'h0);
    chk(rd, 32'h80);
  endtask : sc_underflow
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    sc_reset;
    sc_call_wrap;
    sc_ret_flag;
    sc_irq_hold;
    sc_underflow;
    test_done;
  end
endmodule : test_ras_top
`default_nettype wire
